/* pkg/cefts_consts.svh */
// Register offsets, field positions, reset values and thresholds of the CAN error/time-stamp block
//
// Behaviour
// - Each error-event flag sets on its event, whatever the enables say.
// - Software clears an event flag by writing 0; a same-cycle set wins.
// - Bus error flag sets on any bus error; overload flag on overload condition.
// - Warning flag sets on first rise above 95; re-arms when both below 95.
// - Error-passive flag sets on first rise above 127; re-arms when both below 127.
// - Bus-off entry flag sets when TEC passes 255, automatic-halt handling included.
// - Recovery flag sets after 128 runs of 11 recessive bits, handling 00b/10b/11b.
// - No recovery flag on reset mode, forced return, handling 01b, or 11b halted.
// - Overrun flag sets on overrun in mailbox 0-31, or 0-23/FIFO in FIFO mode.
// - Overwrite mode never sets overrun; it pulses reception-complete request instead.
// - In operation mode, 32 consecutive dominant bits set the bus lock flag.
// - After clear, lock detection re-arms on a recessive bit or mode re-entry.
// - Receive and transmit error counters are readable and follow ISO counting.
// - Error-code flags except output mode clear on write 0; set wins unless output mode 0 already holds a code.
// - Stuff, form, ACK and CRC errors each set their own code flag.
// - Recessive and dominant bit errors each set their own code flag.
// - Form error in ACK delimiter while transmitting sets its own flag.
// - Output mode 0 keeps only first error code; 1 accumulates all codes.
// - A 16-bit time stamp counter is read live by the time-stamp register.
// - The counter advances every selected multiple of one bit time.
// - Counter holds in sleep and halt, cleared in reset mode.
// - Storing a received message copies the counter into the mailbox stamp fields.
// - Error interrupt request is high while any enabled event flag is set.
// - Reset mode clears event flags, counters, time stamp, error codes but output mode.
`ifndef CEFTS_CONSTS_SVH
`define CEFTS_CONSTS_SVH

// Register index map
`define CEFTS_ADR_W            4
`define CEFTS_DAT_W            16
`define CEFTS_ADR_EVT_FLAGS    4'h0
`define CEFTS_ADR_EVT_ENABLES  4'h1
`define CEFTS_ADR_REC          4'h2
`define CEFTS_ADR_TEC          4'h3
`define CEFTS_ADR_ERR_CODE     4'h4
`define CEFTS_ADR_TIMESTAMP    4'h5
`define CEFTS_ADR_CONTROL      4'h6

// Event flag positions
`define CEFTS_EV_BUS_ERR       0
`define CEFTS_EV_WARN          1
`define CEFTS_EV_PASSIVE       2
`define CEFTS_EV_BOFF_ENTRY    3
`define CEFTS_EV_BOFF_RECOV    4
`define CEFTS_EV_OVERRUN       5
`define CEFTS_EV_OVERLOAD      6
`define CEFTS_EV_BUS_LOCK      7

// Error code bit 7: output mode
`define CEFTS_EC_MODE_BIT      7

// Control register fields
`define CEFTS_CTL_MODE_LSB     0
`define CEFTS_CTL_BOM_LSB      2
`define CEFTS_CTL_TIMESTAMP_PRESCALER_LSB     4
`define CEFTS_CTL_FORCED_BUS_OFF_RETURN_BIT     8

// Thresholds and counts
`define CEFTS_WARN_LIMIT       9'h05F
`define CEFTS_PASSIVE_LIMIT    9'h07F
`define CEFTS_BOFF_LIMIT       9'h0FF
`define CEFTS_REC_MAX          9'h0FF
`define CEFTS_TEC_STEP         9'h008
`define CEFTS_REC_STEP         9'h008
`define CEFTS_RECOV_RUNS       8'h80
`define CEFTS_LOCK_BITS        6'h20
`define CEFTS_MAX_MBX_FIFO     5'h17

// Reset values
`define CEFTS_RST_BYTE         8'h00
`define CEFTS_RST_STAMP        16'h0000
`define CEFTS_RST_CNT          9'h000

`endif

/* pkg/cefts_pkg.sv */
// Types shared by the CAN error/time-stamp block
package cefts_pkg;

  // Encoding by order: 00 op, 01 reset, 10 halt, 11 sleep
  typedef enum logic [1:0] {
    CEFTS_OPERATION,
    CEFTS_RESET,
    CEFTS_HALT,
    CEFTS_SLEEP
  } cefts_mode_e;

  // Error code pulses from the protocol engine
  typedef struct packed {
    logic ack_delimiter_error_code;
    logic dominant_bit_error_code;
    logic recessive_bit_error_code;
    logic crc_error_code;
    logic ack_error_code;
    logic form_error_code;
    logic stuff_error_code;
  } cefts_err_s;

  // Error counter step pulses
  typedef struct packed {
    logic rec_inc1;
    logic rec_inc8;
    logic rec_dec;
    logic tec_inc8;
    logic tec_dec;
  } cefts_cnt_s;

  // Overrun report from the mailbox logic
  typedef struct packed {
    logic       hit;
    logic       in_fifo;
    logic [4:0] mailbox;
  } cefts_ovr_s;

  // Mailbox stamp write
  typedef struct packed {
    logic        we;
    logic [7:0]  stamp_high_field;
    logic [7:0]  stamp_low_field;
  } cefts_stamp_s;

  typedef struct packed {
    logic [7:0]   evt_flags;
    logic [7:0]   evt_enables;
    logic [8:0]   rec;
    logic [8:0]   tec;
    logic [7:0]   err_code;
    logic [15:0]  stamp;
    logic [2:0]   presc;
    logic [1:0]   mode;
    logic [1:0]   bus_off_handling_select;
    logic [1:0]   timestamp_prescaler;
    logic         warn_armed;
    logic         passive_armed;
    logic         bus_off;
    logic         halt_seen;
    logic [7:0]   recov_runs;
    logic         lock_armed;
    logic [5:0]   dom_run;
    logic [15:0]  rd_data;
    logic         err_irq;
    logic         rx_done_irq;
    logic         auto_halt;
    cefts_stamp_s stamp_out;
  } cefts_state_s;

endpackage

/* core/cefts_core.sv */
// CAN error flags, error counters, error code capture and time stamp counter
`timescale 1ns/1ps
`include "cefts_consts.svh"

module cefts_core (
  input  wire logic                      i_clk,
  input  wire logic                      i_arst_n,
  input  wire logic [`CEFTS_ADR_W-1:0]   i_addr,
  input  wire logic [`CEFTS_DAT_W-1:0]   i_wdata,
  input  wire logic                      i_wr,
  input  wire logic                      i_rd,
  input  wire logic                      i_bit_tick,
  input  wire logic                      i_bus_bit,
  input  wire logic                      i_rec11_run,
  input  wire logic                      i_overload,
  input  wire logic                      i_overwrite_mode,
  input  wire logic                      i_fifo_mode,
  input  wire logic                      i_rx_store,
  input  wire cefts_pkg::cefts_err_s     i_err,
  input  wire cefts_pkg::cefts_cnt_s     i_cnt,
  input  wire cefts_pkg::cefts_ovr_s     i_ovr,
  output logic [`CEFTS_DAT_W-1:0]        o_rdata,
  output logic                           o_err_irq,
  output logic                           o_rx_done_irq,
  output logic                           o_bus_off,
  output logic                           o_auto_halt,
  output cefts_pkg::cefts_stamp_s        o_stamp
);
  import cefts_pkg::*;

  cefts_state_s st_ff;
  cefts_state_s nxt_st;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic wr_hit(input logic [`CEFTS_ADR_W-1:0] adr);
    wr_hit = i_wr && (i_addr == adr);
  endfunction

  // Written 0 clears; a hardware set wins
  function automatic logic [7:0] clr_set(input logic [7:0] cur, input logic wr,
                                         input logic [7:0] wd, input logic [7:0] set);
    clr_set = (wr ? (cur & wd) : cur) | set;
  endfunction

  function automatic logic [8:0] sat_add(input logic [8:0] a, input logic [8:0] b);
    logic [9:0] s;
    s = {1'b0, a} + {1'b0, b};
    sat_add = s[9] ? 9'h1FF : s[8:0];
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic [7:0] ev_set;
  logic [6:0] ec_set;
  logic       above_warn;
  logic       below_warn;
  logic       above_pass;
  logic       below_pass;
  logic       in_reset;
  logic       in_op;
  logic       ovr_ok;
  logic       boff_enter;
  logic       recov_done;
  logic       forced_ret;
  logic       dominant_bit;
  logic [2:0] presc_top;

  always_comb begin
    nxt_st       = st_ff;
    ev_set       = 8'h00;
    in_reset     = (st_ff.mode == 2'(CEFTS_RESET));
    in_op        = (st_ff.mode == 2'(CEFTS_OPERATION));
    forced_ret   = wr_hit(`CEFTS_ADR_CONTROL) && i_wdata[`CEFTS_CTL_FORCED_BUS_OFF_RETURN_BIT];
    dominant_bit = i_bit_tick && !i_bus_bit;

    // Control and enable registers are kept through reset mode
    if (wr_hit(`CEFTS_ADR_CONTROL)) begin
      nxt_st.mode = i_wdata[`CEFTS_CTL_MODE_LSB +: 2];
      nxt_st.bus_off_handling_select  = i_wdata[`CEFTS_CTL_BOM_LSB +: 2];
      nxt_st.timestamp_prescaler = i_wdata[`CEFTS_CTL_TIMESTAMP_PRESCALER_LSB +: 2];
    end
    if (wr_hit(`CEFTS_ADR_EVT_ENABLES)) begin
      nxt_st.evt_enables = i_wdata[7:0];
    end

    // ----------------------------------------------------------------
    // Error counters
    // ----------------------------------------------------------------
    if (!st_ff.bus_off) begin
      if (i_cnt.rec_inc8) begin
        nxt_st.rec = sat_add(st_ff.rec, `CEFTS_REC_STEP);
      end else if (i_cnt.rec_inc1) begin
        nxt_st.rec = sat_add(st_ff.rec, 9'h001);
      end else if (i_cnt.rec_dec) begin
        // Above 127 a decrement lands on 127
        if (st_ff.rec > `CEFTS_PASSIVE_LIMIT) begin
          nxt_st.rec = `CEFTS_PASSIVE_LIMIT;
        end else if (st_ff.rec != 9'h000) begin
          nxt_st.rec = st_ff.rec - 9'h001;
        end
      end
      if (nxt_st.rec > `CEFTS_REC_MAX) begin
        nxt_st.rec = `CEFTS_REC_MAX;
      end
      if (i_cnt.tec_inc8) begin
        nxt_st.tec = sat_add(st_ff.tec, `CEFTS_TEC_STEP);
      end else if (i_cnt.tec_dec && st_ff.tec != 9'h000) begin
        nxt_st.tec = st_ff.tec - 9'h001;
      end
    end

    above_warn = (nxt_st.rec > `CEFTS_WARN_LIMIT) || (nxt_st.tec > `CEFTS_WARN_LIMIT);
    below_warn = (nxt_st.rec < `CEFTS_WARN_LIMIT) && (nxt_st.tec < `CEFTS_WARN_LIMIT);
    above_pass = (nxt_st.rec > `CEFTS_PASSIVE_LIMIT) || (nxt_st.tec > `CEFTS_PASSIVE_LIMIT);
    below_pass = (nxt_st.rec < `CEFTS_PASSIVE_LIMIT) && (nxt_st.tec < `CEFTS_PASSIVE_LIMIT);

    // One set per excursion over the limit
    if (above_warn && st_ff.warn_armed) begin
      ev_set[`CEFTS_EV_WARN] = 1'b1;
      nxt_st.warn_armed      = 1'b0;
    end else if (below_warn) begin
      nxt_st.warn_armed = 1'b1;
    end
    if (above_pass && st_ff.passive_armed) begin
      ev_set[`CEFTS_EV_PASSIVE] = 1'b1;
      nxt_st.passive_armed      = 1'b0;
    end else if (below_pass) begin
      nxt_st.passive_armed = 1'b1;
    end

    // ----------------------------------------------------------------
    // Bus-off entry and recovery
    // ----------------------------------------------------------------
    boff_enter = !st_ff.bus_off && (nxt_st.tec > `CEFTS_BOFF_LIMIT);
    recov_done = st_ff.bus_off && i_rec11_run && (st_ff.recov_runs == `CEFTS_RECOV_RUNS - 8'h01);
    if (boff_enter) begin
      ev_set[`CEFTS_EV_BOFF_ENTRY] = 1'b1;
      nxt_st.bus_off               = 1'b1;
      nxt_st.recov_runs            = 8'h00;
      nxt_st.halt_seen             = 1'b0;
      // Handling 01b requests a halt
      nxt_st.auto_halt             = (st_ff.bus_off_handling_select == 2'b01);
    end else if (st_ff.bus_off) begin
      if (st_ff.mode == 2'(CEFTS_HALT)) begin
        nxt_st.halt_seen = 1'b1;
      end
      if (forced_ret) begin
        nxt_st.bus_off = 1'b0;
      end else if (recov_done) begin
        nxt_st.bus_off = 1'b0;
        if (st_ff.bus_off_handling_select == 2'b00 || st_ff.bus_off_handling_select == 2'b10 ||
            (st_ff.bus_off_handling_select == 2'b11 && !st_ff.halt_seen && st_ff.mode != 2'(CEFTS_HALT))) begin
          ev_set[`CEFTS_EV_BOFF_RECOV] = 1'b1;
        end
      end else if (i_rec11_run) begin
        nxt_st.recov_runs = st_ff.recov_runs + 8'h01;
      end
      if (!nxt_st.bus_off) begin
        nxt_st.rec       = `CEFTS_RST_CNT;
        nxt_st.tec       = `CEFTS_RST_CNT;
        nxt_st.auto_halt = 1'b0;
      end
    end

    // ----------------------------------------------------------------
    // Error codes and bus error
    // ----------------------------------------------------------------
    ec_set = i_err;
    // First-error mode blocks new codes until cleared
    if (!st_ff.err_code[`CEFTS_EC_MODE_BIT] && (st_ff.err_code[6:0] != 7'h00)) begin
      ec_set = 7'h00;
    end
    nxt_st.err_code = clr_set(st_ff.err_code, wr_hit(`CEFTS_ADR_ERR_CODE),
                              {1'b0, i_wdata[6:0]}, {1'b0, ec_set});
    if (wr_hit(`CEFTS_ADR_ERR_CODE)) begin
      nxt_st.err_code[`CEFTS_EC_MODE_BIT] = i_wdata[`CEFTS_EC_MODE_BIT];
    end
    ev_set[`CEFTS_EV_BUS_ERR]  = (i_err != '0);
    ev_set[`CEFTS_EV_OVERLOAD] = i_overload;

    // ----------------------------------------------------------------
    // Overrun versus overwrite
    // ----------------------------------------------------------------
    ovr_ok = i_fifo_mode ? (i_ovr.in_fifo || i_ovr.mailbox <= `CEFTS_MAX_MBX_FIFO) : 1'b1;
    ev_set[`CEFTS_EV_OVERRUN] = i_ovr.hit && !i_overwrite_mode && ovr_ok;
    nxt_st.rx_done_irq        = i_ovr.hit && i_overwrite_mode;

    // ----------------------------------------------------------------
    // Bus lock detection
    // ----------------------------------------------------------------
    if (!in_op) begin
      nxt_st.dom_run    = 6'h00;
      nxt_st.lock_armed = 1'b1;
    end else if (i_bit_tick) begin
      if (i_bus_bit) begin
        nxt_st.dom_run = 6'h00;
        if (!st_ff.evt_flags[`CEFTS_EV_BUS_LOCK]) begin
          nxt_st.lock_armed = 1'b1;
        end
      end else if (st_ff.dom_run != `CEFTS_LOCK_BITS) begin
        nxt_st.dom_run = st_ff.dom_run + 6'h01;
      end
    end
    if (in_op && dominant_bit && st_ff.lock_armed && (st_ff.dom_run == `CEFTS_LOCK_BITS - 6'h01)) begin
      ev_set[`CEFTS_EV_BUS_LOCK] = 1'b1;
      nxt_st.lock_armed          = 1'b0;
    end

    // ----------------------------------------------------------------
    // Event flags
    // ----------------------------------------------------------------
    nxt_st.evt_flags = clr_set(st_ff.evt_flags, wr_hit(`CEFTS_ADR_EVT_FLAGS),
                               i_wdata[7:0], ev_set);

    // ----------------------------------------------------------------
    // Time stamp
    // ----------------------------------------------------------------
    presc_top = 3'((4'h1 << st_ff.timestamp_prescaler) - 4'h1);
    if (in_op && i_bit_tick) begin
      if (st_ff.presc >= presc_top) begin
        nxt_st.presc = 3'h0;
        nxt_st.stamp = st_ff.stamp + 16'h0001;
      end else begin
        nxt_st.presc = st_ff.presc + 3'h1;
      end
    end
    nxt_st.stamp_out.we = i_rx_store;
    if (i_rx_store) begin
      nxt_st.stamp_out.stamp_low_field  = st_ff.stamp[7:0];
      nxt_st.stamp_out.stamp_high_field = st_ff.stamp[15:8];
    end

    // ----------------------------------------------------------------
    // Reset mode reinitialisation
    // ----------------------------------------------------------------
    // Output mode select survives
    if (in_reset) begin
      nxt_st.evt_flags      = `CEFTS_RST_BYTE;
      nxt_st.rec            = `CEFTS_RST_CNT;
      nxt_st.tec            = `CEFTS_RST_CNT;
      nxt_st.stamp          = `CEFTS_RST_STAMP;
      nxt_st.presc          = 3'h0;
      nxt_st.err_code[6:0]  = 7'h00;
      nxt_st.bus_off        = 1'b0;
      nxt_st.auto_halt      = 1'b0;
      nxt_st.warn_armed     = 1'b1;
      nxt_st.passive_armed  = 1'b1;
    end

    nxt_st.err_irq = (nxt_st.evt_flags & nxt_st.evt_enables) != 8'h00;

    // ----------------------------------------------------------------
    // Read port
    // ----------------------------------------------------------------
    nxt_st.rd_data = '0;
    if (i_rd) begin
      unique case (i_addr)
        `CEFTS_ADR_EVT_FLAGS:   nxt_st.rd_data = {8'h00, st_ff.evt_flags};
        `CEFTS_ADR_EVT_ENABLES: nxt_st.rd_data = {8'h00, st_ff.evt_enables};
        `CEFTS_ADR_REC:         nxt_st.rd_data = {8'h00, st_ff.rec[7:0]};
        // Bus-off TEC exceeds 8 bits; read the ceiling
        `CEFTS_ADR_TEC:         nxt_st.rd_data = {8'h00, st_ff.tec[8] ? 8'hFF : st_ff.tec[7:0]};
        `CEFTS_ADR_ERR_CODE:    nxt_st.rd_data = {8'h00, st_ff.err_code};
        `CEFTS_ADR_TIMESTAMP:   nxt_st.rd_data = st_ff.stamp;
        `CEFTS_ADR_CONTROL:     nxt_st.rd_data = {10'h000, st_ff.timestamp_prescaler, st_ff.bus_off_handling_select, st_ff.mode};
        default:                nxt_st.rd_data = '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_ff               <= '0;
      st_ff.mode          <= 2'(CEFTS_RESET);
      st_ff.warn_armed    <= 1'b1;
      st_ff.passive_armed <= 1'b1;
      st_ff.lock_armed    <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_rdata       = st_ff.rd_data;
  assign o_err_irq     = st_ff.err_irq;
  assign o_rx_done_irq = st_ff.rx_done_irq;
  assign o_bus_off     = st_ff.bus_off;
  assign o_auto_halt   = st_ff.auto_halt;
  assign o_stamp       = st_ff.stamp_out;

endmodule // cefts_core

/* bench/cefts_engine_model.sv */
// Protocol engine stand-in: bit ticks and bus level
`timescale 1ns/1ps

module cefts_engine_model (
  input  wire logic i_clk,
  input  wire logic i_arst_n,
  input  wire logic i_dominant,
  output logic      o_bit_tick,
  output logic      o_bus_bit
);
  logic [1:0] div_ff;

  // -----------------------------------------------------------------
  // Bit timing
  // -----------------------------------------------------------------
  // Four clocks a bit keeps bit counts cheap
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      div_ff     <= 2'h0;
      o_bit_tick <= 1'b0;
      o_bus_bit  <= 1'b1;
    end else begin
      div_ff     <= div_ff + 2'h1;
      o_bit_tick <= (div_ff == 2'h3);
      if (div_ff == 2'h3) begin
        o_bus_bit <= ~i_dominant;
      end
    end
  end
endmodule // cefts_engine_model

/* bench/cefts_core_sva.sv */
// Port assertions of the CAN error/time-stamp block
`timescale 1ns/1ps
`include "cefts_consts.svh"

module cefts_core_sva (
  input wire logic                    i_clk,
  input wire logic                    i_arst_n,
  input wire logic [`CEFTS_ADR_W-1:0] i_addr,
  input wire logic [`CEFTS_DAT_W-1:0] i_wdata,
  input wire logic                    i_wr,
  input wire logic                    i_rd,
  input wire logic                    i_overload,
  input wire logic                    i_overwrite_mode,
  input wire logic                    i_rx_store,
  input wire cefts_pkg::cefts_ovr_s   i_ovr,
  input wire logic [`CEFTS_DAT_W-1:0] o_rdata,
  input wire logic                    o_err_irq,
  input wire logic                    o_rx_done_irq,
  input wire logic                    o_bus_off,
  input wire logic                    o_auto_halt,
  input wire cefts_pkg::cefts_stamp_s o_stamp
);
  import cefts_pkg::*;
  logic [1:0] mode_ff;
  logic [7:0] en_ff;
  logic       op;
  logic       halt;
  logic       rst;

  // -----------------------------------------------------------------
  // Shadow of the mode and enable fields written by software
  // -----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mode_ff <= 2'h1;
      en_ff   <= 8'h00;
    end else begin
      if (i_wr && i_addr == `CEFTS_ADR_CONTROL) mode_ff <= i_wdata[1:0];
      if (i_wr && i_addr == `CEFTS_ADR_EVT_ENABLES) en_ff <= i_wdata[7:0];
    end
  end
  assign op   = (mode_ff == 2'h0);
  assign halt = (mode_ff == 2'h2);
  assign rst  = (mode_ff == 2'h1);

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  sequence s_ovl;
    op && i_overload;
  endsequence
  sequence s_rd_flags;
    op && i_rd && !i_wr && i_addr == `CEFTS_ADR_EVT_FLAGS;
  endsequence
  sequence s_rd_stamp_halt;
    halt && i_rd && i_addr == `CEFTS_ADR_TIMESTAMP;
  endsequence

  a_rdata_idle_zero: assert property (!$past(i_rd) |-> o_rdata == 16'h0000) else $error("rdata not 0");
  a_unmapped_zero: assert property (i_rd && i_addr > `CEFTS_ADR_CONTROL |=> o_rdata == 16'h0000)
    else $error("unmapped read");
  a_overload_sets: assert property (s_ovl ##1 s_rd_flags |=> o_rdata[`CEFTS_EV_OVERLOAD])
    else $error("no overload flag");
  a_stamp_halt_hold: assert property (s_rd_stamp_halt ##1 s_rd_stamp_halt |=> o_rdata == $past(o_rdata))
    else $error("stamp moved");
  a_stamp_we_pulse: assert property (o_stamp.we == $past(i_rx_store)) else $error("stamp we");
  a_stamp_matches: assert property (i_rx_store && i_rd && i_addr == `CEFTS_ADR_TIMESTAMP |=>
    o_rdata == {o_stamp.stamp_high_field, o_stamp.stamp_low_field}) else $error("stamp copy");
  a_rxdone_cause: assert property (o_rx_done_irq |-> $past(i_ovr.hit) && $past(i_overwrite_mode))
    else $error("rx done cause");
  a_auto_halt_boff: assert property (o_auto_halt |-> o_bus_off) else $error("auto halt");
  a_irq_masked: assert property (en_ff == 8'h00 && $past(en_ff) == 8'h00 |-> !o_err_irq)
    else $error("masked irq");
  a_reset_mode_clear: assert property (rst && $past(rst) && i_rd && i_addr inside {4'h0, 4'h2, 4'h3, 4'h5}
    |=> o_rdata == 16'h0000) else $error("reset mode state");
endmodule // cefts_core_sva

bind cefts_core cefts_core_sva cefts_core_sva_inst (.*);

/* bench/cefts_core_tb.sv */
// Testbench for the CAN error/time-stamp block
`timescale 1ns/1ps
`include "cefts_consts.svh"

module cefts_core_tb;
  import cefts_pkg::*;
  logic         i_clk, i_arst_n, i_wr, i_rd, i_bit_tick, i_bus_bit, i_rec11_run, i_overload;
  logic         i_overwrite_mode, i_fifo_mode, i_rx_store, dominant, o_err_irq, o_rx_done_irq, o_bus_off, o_auto_halt;
  logic [3:0]   i_addr;
  logic [15:0]  i_wdata, o_rdata, d1, d2;
  cefts_err_s   i_err;
  cefts_cnt_s   i_cnt;
  cefts_ovr_s   i_ovr;
  cefts_stamp_s o_stamp;
  int           fail_count, comparisons;

  cefts_core cefts_core_inst (.*);
  cefts_engine_model cefts_engine_model_inst (.i_clk, .i_arst_n, .i_dominant(dominant), .o_bit_tick(i_bit_tick),
    .o_bus_bit(i_bus_bit));

  // -----------------------------------------------------------------
  // Bus and compare helpers
  // -----------------------------------------------------------------
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d, input logic ovl = 1'b0, input cefts_err_s e = '0);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    i_overload <= ovl;
    i_err <= e;
    @(posedge i_clk);
    i_wr <= 1'b0;
    i_overload <= 1'b0;
    i_err <= '0;
  endtask
  task automatic rd2(input logic [3:0] a, output logic [15:0] r1, output logic [15:0] r2);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    #1 r1 = o_rdata;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 r2 = o_rdata;
  endtask
  task automatic rdchk(input string n, input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
    logic [15:0] r;
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 r = o_rdata;
    check(n, r & m, e);
  endtask
  task automatic cnt(input logic [4:0] c, input int n);
    repeat (n) begin
      @(posedge i_clk);
      i_cnt <= c;
      @(posedge i_clk);
      i_cnt <= '0;
    end
  endtask

  // -----------------------------------------------------------------
  // Scenarios
  // -----------------------------------------------------------------
  task automatic test_reset_and_flags();
    rdchk("flags rst", 4'h0, 16'hFFFF, 16'h0000);
    rdchk("stamp rst", 4'h5, 16'hFFFF, 16'h0000);
    rdchk("unmapped", 4'hF, 16'hFFFF, 16'h0000);
    wr(4'h6, 16'h0000);
    wr(4'h1, 16'h0040);
    wr(4'h0, 16'h0000, 1'b1); // Set beside clear
    rdchk("set wins", 4'h0, 16'h0040, 16'h0040);
    check("irq on", o_err_irq, 16'h0001);
    @(posedge i_clk);
    i_overload <= 1'b1;
    @(posedge i_clk);
    i_overload <= 1'b0;
    i_rd <= 1'b1;
    i_addr <= 4'h0;
    @(posedge i_clk);
    i_rd <= 1'b0;
    wr(4'h0, 16'h0000);
    wr(4'h1, 16'h0000);
    rdchk("cleared", 4'h0, 16'hFFFF, 16'h0000);
    check("irq off", o_err_irq, 16'h0000);
    $display("test_reset_and_flags done");
  endtask

  task automatic test_error_code();
    wr(4'h4, 16'h0000, 1'b0, 7'h01);
    wr(4'h4, 16'h0000);
    wr(4'h0, 16'h0000, 1'b0, 7'h01);
    wr(4'h1, 16'h0000, 1'b0, 7'h08);
    rdchk("first code", 4'h4, 16'hFFFF, 16'h0001);
    rdchk("bus err", 4'h0, 16'h0001, 16'h0001);
    wr(4'h4, 16'h0080);
    for (int b = 1; b < 7; b++) wr(4'h1, 16'h0000, 1'b0, cefts_err_s'(7'h01 << b));
    rdchk("all codes", 4'h4, 16'hFFFF, 16'h00FE);
    wr(4'h4, 16'h0000);
    $display("test_error_code done");
  endtask

  task automatic test_counters();
    wr(4'h0, 16'h0000);
    cnt(5'h02, 12);
    rdchk("tec 96", 4'h3, 16'hFFFF, 16'h0060);
    rdchk("warn", 4'h0, 16'h0006, 16'h0002);
    wr(4'h0, 16'h0000);
    cnt(5'h01, 1);
    cnt(5'h02, 4);
    rdchk("no rearm", 4'h0, 16'h0006, 16'h0000);
    cnt(5'h02, 1);
    rdchk("passive", 4'h0, 16'h0006, 16'h0004);
    cnt(5'h02, 16);
    rdchk("boff entry", 4'h0, 16'h0018, 16'h0008);
    check("bus off", o_bus_off, 16'h0001);
    repeat (127) begin
      @(posedge i_clk);
      i_rec11_run <= 1'b1;
      @(posedge i_clk);
      i_rec11_run <= 1'b0;
    end
    rdchk("early recov", 4'h0, 16'h0010, 16'h0000);
    wr(4'h1, 16'h0000);
    i_rec11_run <= 1'b1;
    @(posedge i_clk);
    i_rec11_run <= 1'b0;
    rdchk("recovered", 4'h0, 16'h0010, 16'h0010);
    wr(4'h0, 16'h0000);
    wr(4'h6, 16'h0004);
    cnt(5'h02, 33);
    check("auto halt", o_auto_halt, 16'h0001);
    rdchk("entry 01b", 4'h0, 16'h0008, 16'h0008);
    wr(4'h6, 16'h0104);
    rdchk("forced ret", 4'h0, 16'h0010, 16'h0000);
    check("left boff", o_bus_off, 16'h0000);
    wr(4'h6, 16'h0000);
    cnt(5'h10, 3);
    rdchk("rec", 4'h2, 16'hFFFF, 16'h0003);
    $display("test_counters done");
  endtask

  task automatic test_overrun_lock();
    wr(4'h0, 16'h0000);
    i_overwrite_mode <= 1'b1;
    @(posedge i_clk);
    i_ovr <= '{1'b1, 1'b0, 5'h05};
    @(posedge i_clk);
    i_ovr <= '0;
    #1 check("rx done", o_rx_done_irq, 16'h0001);
    rdchk("no overrun", 4'h0, 16'h0020, 16'h0000);
    i_overwrite_mode <= 1'b0;
    i_fifo_mode <= 1'b1;
    @(posedge i_clk);
    i_ovr <= '{1'b1, 1'b0, 5'h17};
    @(posedge i_clk);
    i_ovr <= '0;
    rdchk("overrun", 4'h0, 16'h0020, 16'h0020);
    dominant <= 1'b1;
    repeat (116) @(posedge i_clk);
    rdchk("lock early", 4'h0, 16'h0080, 16'h0000);
    repeat (16) @(posedge i_clk);
    rdchk("lock", 4'h0, 16'h0080, 16'h0080);
    wr(4'h0, 16'h0000);
    repeat (160) @(posedge i_clk);
    rdchk("no relock", 4'h0, 16'h0080, 16'h0000);
    dominant <= 1'b0;
    repeat (12) @(posedge i_clk);
    dominant <= 1'b1;
    repeat (144) @(posedge i_clk);
    rdchk("relock", 4'h0, 16'h0080, 16'h0080);
    dominant <= 1'b0;
    $display("test_overrun_lock done");
  endtask

  task automatic test_stamp();
    for (int p = 0; p < 2; p++) begin
      wr(4'h6, 16'(p << 4));
      rd2(4'h5, d1, d2);
      repeat (36) @(posedge i_clk);
      rd2(4'h5, d2, d2);
      check("stamp step", d2 - d1, 16'h000A >> p);
    end
    wr(4'h6, 16'h0002);
    rd2(4'h5, d1, d2);
    check("halt hold", d2, d1);
    wr(4'h6, 16'h0000);
    @(posedge i_clk);
    i_rx_store <= 1'b1;
    i_rd <= 1'b1;
    i_addr <= 4'h5;
    @(posedge i_clk);
    i_rx_store <= 1'b0;
    i_rd <= 1'b0;
    #1 check("stamp copy", {o_stamp.stamp_high_field, o_stamp.stamp_low_field}, o_rdata);
    check("stamp we", o_stamp.we, 16'h0001);
    wr(4'h6, 16'h0001);
    rd2(4'h5, d1, d2);
    check("stamp cleared", d2, 16'h0000);
    $display("test_stamp done");
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  // Nearly twenty times the expected run
  initial begin
    #2_000_000;
    fail_count++;
    print_verdict();
  end

  initial begin
    {i_arst_n, i_wr, i_rd, i_rec11_run, i_overload, i_overwrite_mode, i_fifo_mode, i_rx_store, dominant} = '0;
    {i_addr, i_wdata, i_err, i_cnt, i_ovr} = '0;
    fail_count = 0;
    comparisons = 0;
    repeat (10) @(posedge i_clk);
    i_arst_n <= 1'b1;
    test_reset_and_flags();
    test_error_code();
    test_counters();
    test_overrun_lock();
    test_stamp();
    print_verdict();
  end
endmodule // cefts_core_tb
